// file: src/unsd_map.vh
`ifndef UNSD_MAP_VH
`define UNSD_MAP_VH
// ----------------------------------------
// Register word offsets (byte address / 4)
// ----------------------------------------
`define UNSD_A_NODE_STATE 3'h0
`define UNSD_A_ALT_EVENT 3'h1
`define UNSD_A_FUNC_ADDR 3'h2
`define UNSD_A_EP_CTRL 3'h3
`define UNSD_A_EP0_DATA 3'h4
`define UNSD_A_EP0_STAT 3'h5
// ----------------------------------------
// Node state codes
// ----------------------------------------
`define UNSD_ST_RESET 2'h0
`define UNSD_ST_WAKE 2'h1
`define UNSD_ST_RUN 2'h2
`define UNSD_ST_SLEEP 2'h3
// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define UNSD_EV_RESET 0
`define UNSD_EV_SD3 1
`define UNSD_EV_SD5 2
`define UNSD_EV_RESUME 3
`define UNSD_EV_EOP 4
// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define UNSD_CLK_KHZ 10000
`define UNSD_IDLE3_MS 3
`define UNSD_IDLE5_MS 5
`define UNSD_IDLE3_CYC (`UNSD_IDLE3_MS * `UNSD_CLK_KHZ)
`define UNSD_IDLE5_CYC (`UNSD_IDLE5_MS * `UNSD_CLK_KHZ)
`define UNSD_EP0_DEPTH 8
`define UNSD_NUM_EP 7
`endif

// file: src/unsd_node.v
`timescale 1ns/1ps
// Operation
// - Exactly one of four node states
// - Line conditions flagged in event register
// - 3 ms idle sets idle flag
// - Sleeping keeps FIFO data but clears endpoint state
// - Waking state drives constant K
// - Sleeping still detects resume and reset
// - State changes only on firmware write
// - Non-running state holds endpoints reset
// - Decode 00 reset 10 run 11 sleep 01 wake
// - Match address then endpoints in parallel
// - One FIFO of 8 bytes, on ep zero only
// - Lower endpoint wins same number, direction
// - Default address accepted on any endpoint
// - Ep zero resends packet after error
// - Errored receptions silently discarded
`include "unsd_map.vh"
module unsd_node #(
	parameter IDLE3_CYC = `UNSD_IDLE3_CYC,
	parameter IDLE5_CYC = `UNSD_IDLE5_CYC
) (
	input wire mclk_in,
	input wire rst_in,
	input wire [2:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	input wire line_activity_in,
	input wire line_resume_in,
	input wire line_reset_in,
	input wire line_eop_in,
	input wire tok_valid_in,
	input wire tok_in_dir_in,
	input wire [6:0] tok_addr_in,
	input wire [3:0] tok_ep_in,
	input wire rx_valid_in,
	input wire [7:0] rx_data_in,
	input wire rx_end_in,
	input wire rx_error_in,
	input wire tx_ack_in,
	input wire tx_error_in,
	input wire tx_next_in,
	output reg [7:0] tx_data_out,
	output reg tx_active_out,
	output reg drive_k_out,
	output reg low_power_out,
	output reg [2:0] ep_select_out,
	output reg ep_hit_out
);
	// ----------------------------------------
	// Line input synchronisers
	// ----------------------------------------
	reg [3:0] sync_a;
	reg [3:0] sync_b;
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= {line_eop_in, line_reset_in, line_resume_in, line_activity_in};
			sync_b <= sync_a;
		end
	end
	wire act_s = sync_b[0];
	wire resume_s = sync_b[1];
	wire lreset_s = sync_b[2];
	wire eop_s = sync_b[3];
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [1:0] node_state_field;
	reg [4:0] alternate_event_reg;
	reg [6:0] function_address_reg;
	reg [3:0] ep_num [0:6];
	reg [6:0] ep_en;
	reg [6:0] ep_iso;
	reg default_address_enable;
	reg [7:0] ep_zero_fifo [0:7];
	reg [3:0] ep0_count;
	reg [2:0] ep0_rd;
	reg ep0_rx_done;
	reg ep0_tx_done;
	reg ep0_rx_armed;
	reg [6:0] ep_fill;
	reg [22:0] idle_cnt;
	reg [4:0] prev_line;
	wire running = (node_state_field == `UNSD_ST_RUN);
	wire sleeping = (node_state_field == `UNSD_ST_SLEEP);
	wire acc = (avs_read_in | avs_write_in) & avs_waitrequest_out;
	wire wr = avs_write_in & ~avs_waitrequest_out;
	wire rd = avs_read_in & acc;
	wire idle_3ms_flag = (idle_cnt == IDLE3_CYC[22:0]);
	wire idle_5ms_flag = (idle_cnt == IDLE5_CYC[22:0]);
	wire [4:0] line_now = {eop_s, 1'b0, 1'b0, resume_s, lreset_s};
	wire [4:0] ev_set;
	assign ev_set[`UNSD_EV_RESET] = line_now[0] & ~prev_line[0];
	assign ev_set[`UNSD_EV_RESUME] = line_now[1] & ~prev_line[1] & sleeping;
	assign ev_set[`UNSD_EV_EOP] = line_now[4] & ~prev_line[4];
	assign ev_set[`UNSD_EV_SD3] = idle_3ms_flag;
	assign ev_set[`UNSD_EV_SD5] = idle_5ms_flag;
	// ----------------------------------------
	// Endpoint match, lower endpoint first
	// ----------------------------------------
	reg [2:0] hit_idx;
	reg hit;
	integer i;
	always @* begin
		hit = 1'b0;
		hit_idx = 3'h0;
		for (i = `UNSD_NUM_EP - 1; i >= 0; i = i - 1) begin
			if (ep_en[i] && ep_num[i] == tok_ep_in && !(ep_iso[i] && ep_fill[i] == (i[0] ^ tok_in_dir_in))
				&& (i == 0 || i[0] == tok_in_dir_in)) begin
				hit = 1'b1;
				hit_idx = i[2:0];
			end
		end
	end
	wire addr_ok = (tok_addr_in == function_address_reg) ||
		(default_address_enable && tok_addr_in == 7'h00);
	// ----------------------------------------
	// Main sequential logic
	// ----------------------------------------
	integer j;
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			node_state_field <= `UNSD_ST_RESET;
			alternate_event_reg <= 5'h00;
			function_address_reg <= 7'h00;
			ep_en <= 7'h00;
			ep_iso <= 7'h00;
			default_address_enable <= 1'b0;
			ep0_count <= 4'h0;
			ep0_rd <= 3'h0;
			ep0_rx_done <= 1'b0;
			ep0_tx_done <= 1'b0;
			ep0_rx_armed <= 1'b0;
			ep_fill <= 7'h00;
			idle_cnt <= 23'h0;
			prev_line <= 5'h00;
			avs_readdata_out <= 32'h0;
			avs_waitrequest_out <= 1'b1;
			tx_data_out <= 8'h00;
			tx_active_out <= 1'b0;
			drive_k_out <= 1'b0;
			low_power_out <= 1'b0;
			ep_select_out <= 3'h0;
			ep_hit_out <= 1'b0;
			for (j = 0; j < `UNSD_NUM_EP; j = j + 1)
				ep_num[j] <= 4'h0;
			for (j = 0; j < `UNSD_EP0_DEPTH; j = j + 1)
				ep_zero_fifo[j] <= 8'h00;
		end else begin
			prev_line <= line_now;
			avs_waitrequest_out <= ~acc;
			if (act_s || idle_5ms_flag)
				idle_cnt <= act_s ? 23'h0 : idle_cnt;
			else
				idle_cnt <= idle_cnt + 23'h1;
			// Event flags, set wins over clear-on-read
			if (rd && avs_address_in == `UNSD_A_ALT_EVENT)
				alternate_event_reg <= ev_set;
			else
				alternate_event_reg <= alternate_event_reg | ev_set;
			// State changes only by firmware write
			if (wr && avs_address_in == `UNSD_A_NODE_STATE)
				node_state_field <= avs_writedata_in[1:0];
			drive_k_out <= (node_state_field == `UNSD_ST_WAKE);
			low_power_out <= sleeping;
			if (wr && avs_address_in == `UNSD_A_FUNC_ADDR)
				function_address_reg <= avs_writedata_in[6:0];
			if (wr && avs_address_in == `UNSD_A_EP_CTRL) begin
				ep_en <= avs_writedata_in[6:0];
				ep_iso <= {avs_writedata_in[13:8], 1'b0};
				default_address_enable <= avs_writedata_in[15];
				for (j = 0; j < `UNSD_NUM_EP; j = j + 1)
					ep_num[j] <= avs_writedata_in[16 + j*2 +: 2] == 2'h0 ? j[3:0] : ep_num[j];
			end
			// Firmware loads ep zero; write with bit 8 flushes
			if (wr && avs_address_in == `UNSD_A_EP0_DATA) begin
				if (avs_writedata_in[8]) begin
					ep0_count <= 4'h0;
					ep0_rd <= 3'h0;
					ep0_rx_done <= 1'b0;
					ep0_tx_done <= 1'b0;
				end else if (ep0_count < 4'h8) begin
					ep_zero_fifo[ep0_count[2:0]] <= avs_writedata_in[7:0];
					ep0_count <= ep0_count + 4'h1;
				end
			end
			ep_hit_out <= 1'b0;
			if (!running) begin
				tx_active_out <= 1'b0;
				ep_fill <= 7'h00;
				ep0_rd <= 3'h0;
				ep0_rx_armed <= 1'b0;
			end else if (sleeping) begin
				tx_active_out <= tx_active_out;
			end else begin
				if (tok_valid_in && addr_ok && hit) begin
					ep_select_out <= hit_idx;
					ep_hit_out <= 1'b1;
					if (ep_iso[hit_idx])
						ep_fill[hit_idx] <= ~ep_fill[hit_idx];
					if (hit_idx == 3'h0 && !tok_in_dir_in)
						ep0_rx_armed <= 1'b1;
					if (hit_idx == 3'h0 && tok_in_dir_in && ep0_count != 4'h0) begin
						tx_active_out <= 1'b1;
						ep0_rd <= 3'h0;
						tx_data_out <= ep_zero_fifo[0];
					end
				end
				if (tx_active_out && tx_next_in) begin
					ep0_rd <= ep0_rd + 3'h1;
					tx_data_out <= ep_zero_fifo[ep0_rd + 3'h1];
				end
				if (tx_active_out && tx_error_in) begin
					tx_active_out <= 1'b0;
					ep0_rd <= 3'h0;
				end
				if (tx_active_out && tx_ack_in) begin
					tx_active_out <= 1'b0;
					ep0_count <= 4'h0;
					ep0_tx_done <= 1'b1;
				end
				if (ep0_rx_armed && rx_valid_in && ep0_count < 4'h8) begin
					ep_zero_fifo[ep0_count[2:0]] <= rx_data_in;
					ep0_count <= ep0_count + 4'h1;
				end
				if (rx_end_in && ep0_rx_armed) begin
					ep0_rx_armed <= 1'b0;
					if (rx_error_in)
						ep0_count <= 4'h0;
					else if (ep0_count != 4'h0)
						ep0_rx_done <= 1'b1;
				end
			end
			// Read mux
			if (rd) begin
				case (avs_address_in)
				`UNSD_A_NODE_STATE: avs_readdata_out <= {30'h0, node_state_field};
				`UNSD_A_ALT_EVENT: avs_readdata_out <= {27'h0, alternate_event_reg};
				`UNSD_A_FUNC_ADDR: avs_readdata_out <= {25'h0, function_address_reg};
				`UNSD_A_EP_CTRL: avs_readdata_out <= {16'h0, default_address_enable,
					ep_iso[6:1], 2'h0, ep_en};
				`UNSD_A_EP0_DATA: avs_readdata_out <= {24'h0, ep_zero_fifo[ep0_rd]};
				`UNSD_A_EP0_STAT: avs_readdata_out <= {26'h0, ep0_tx_done, ep0_rx_done,
					ep0_count};
				default: avs_readdata_out <= 32'h0;
				endcase
			end
		end
	end
endmodule // unsd_node

// file: verification/tb.sv
`timescale 1ns/1ps
`include "unsd_map.vh"
module tb;
	// ----------
	// Bench
	// ----------
	localparam int I3 = 30;
	localparam int I5 = 50;
	logic mclk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0, h;
	logic [2:0] avs_address_in = 3'h0, ep_select_out;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic avs_waitrequest_out, tx_active_out, drive_k_out, low_power_out, ep_hit_out;
	logic line_activity_in, line_resume_in, line_reset_in, line_eop_in, tok_valid_in;
	logic tok_in_dir_in, rx_valid_in, rx_end_in, rx_error_in, tx_ack_in, tx_error_in, tx_next_in;
	logic [6:0] tok_addr_in;
	logic [3:0] tok_ep_in;
	logic [7:0] rx_data_in, tx_data_out;
	int n_mismatch = 0, tests_run = 0;
	always #50 mclk_in = ~mclk_in;
	unsd_node #(.IDLE3_CYC(I3), .IDLE5_CYC(I5)) u_unsd_node (.*);
	unsd_host_model u_unsd_host_model (.*);
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{avs_address_in, avs_writedata_in, avs_write_in, avs_read_in} <= {a, d, w, !w};
		do begin
			@(posedge mclk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (n >= 20) chk("waitrequest", 32'h1, 32'h0);
		q = avs_readdata_out;
		{avs_write_in, avs_read_in} <= 2'h0;
		repeat (2) @(posedge mclk_in);
	endtask
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_reset;
		chk("state", {avs_waitrequest_out, drive_k_out, low_power_out}, 32'h4);
		bus(0, `UNSD_A_NODE_STATE, 32'h0);
		chk("state", q[1:0], `UNSD_ST_RESET);
		bus(1, 3'h7, 32'h3);
		bus(0, 3'h7, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_idle;
		bus(1, `UNSD_A_NODE_STATE, `UNSD_ST_RUN);
		bus(0, `UNSD_A_ALT_EVENT, 32'h0);
		u_unsd_host_model.line(4'h1);
		repeat (I3 + 6) @(posedge mclk_in);
		bus(0, `UNSD_A_ALT_EVENT, 32'h0);
		chk("idle3", q[4:1], 4'h1);
		repeat (I5 - I3) @(posedge mclk_in);
		bus(0, `UNSD_A_ALT_EVENT, 32'h0);
		chk("idle5", q[4:1], 4'h2);
		$display("t_idle done");
	endtask
	task automatic t_sleep;
		bus(1, `UNSD_A_NODE_STATE, `UNSD_ST_SLEEP);
		chk("sleep", {drive_k_out, low_power_out}, 32'h1);
		u_unsd_host_model.line(4'h6);
		bus(0, `UNSD_A_ALT_EVENT, 32'h0);
		chk("wake ev", {q[`UNSD_EV_RESUME], q[`UNSD_EV_RESET]}, 32'h3);
		chk("idle5 wake", q[`UNSD_EV_SD5], 32'h1);
		bus(0, `UNSD_A_NODE_STATE, 32'h0);
		chk("state", q[1:0], `UNSD_ST_SLEEP);
		bus(1, `UNSD_A_NODE_STATE, `UNSD_ST_WAKE);
		chk("k", {drive_k_out, low_power_out}, 32'h2);
		repeat (20) @(posedge mclk_in);
		chk("k", drive_k_out, 32'h1);
		bus(1, `UNSD_A_NODE_STATE, `UNSD_ST_RUN);
		u_unsd_host_model.line(4'h8);
		bus(0, `UNSD_A_ALT_EVENT, 32'h0);
		chk("eop", {drive_k_out, q[`UNSD_EV_EOP]}, 32'h1);
		$display("t_sleep done");
	endtask
	task automatic t_ep;
		bus(1, `UNSD_A_FUNC_ADDR, 32'h5);
		bus(1, `UNSD_A_EP_CTRL, 32'h1);
		bus(1, `UNSD_A_EP0_DATA, 32'h100);
		bus(1, `UNSD_A_EP0_DATA, 32'ha5);
		bus(1, `UNSD_A_EP0_DATA, 32'h5a);
		u_unsd_host_model.tok(1, 7'h6, 4'h0, h);
		chk("miss", h, 32'h0);
		for (int i = 0; i < 2; i++) begin
			u_unsd_host_model.tok(1, 7'h5, 4'h0, h);
			chk("hit", {h, ep_select_out, tx_active_out}, 32'h11);
			u_unsd_host_model.hs(!i[0]);
			bus(0, `UNSD_A_EP0_STAT, 32'h0);
			chk("tx done", q[5], 32'(i));
		end
		for (int i = 0; i < 2; i++) begin
			bus(1, `UNSD_A_EP0_DATA, 32'h100);
			u_unsd_host_model.tok(0, 7'h5, 4'h0, h);
			u_unsd_host_model.rx(3, !i[0]);
			bus(0, `UNSD_A_EP0_STAT, 32'h0);
			chk("rx done", {q[4], q[3:0]}, i ? 32'h13 : 32'h0);
		end
		bus(1, `UNSD_A_EP_CTRL, 32'h8001);
		u_unsd_host_model.tok(0, 7'h0, 4'h0, h);
		chk("default", h, 32'h1);
		bus(1, `UNSD_A_NODE_STATE, `UNSD_ST_RESET);
		u_unsd_host_model.tok(0, 7'h0, 4'h0, h);
		chk("reset hit", h, 32'h0);
		$display("t_ep done");
	endtask
	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		t_reset;
		t_idle;
		t_sleep;
		t_ep;
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge mclk_in);
		n_mismatch++;
		end_sim;
	end
endmodule // tb

// file: verification/unsd_host_model.sv
`timescale 1ns/1ps
module unsd_host_model (
	input logic mclk_in,
	input logic ep_hit_out,
	output logic line_activity_in,
	output logic line_resume_in,
	output logic line_reset_in,
	output logic line_eop_in,
	output logic tok_valid_in,
	output logic tok_in_dir_in,
	output logic [6:0] tok_addr_in,
	output logic [3:0] tok_ep_in,
	output logic rx_valid_in,
	output logic [7:0] rx_data_in,
	output logic rx_end_in,
	output logic rx_error_in,
	output logic tx_ack_in,
	output logic tx_error_in,
	output logic tx_next_in
);
	// ----------
	// Host side
	// ----------
	initial {line_activity_in, line_resume_in, line_reset_in, line_eop_in, tok_valid_in,
		tok_in_dir_in, tok_addr_in, tok_ep_in, rx_valid_in, rx_data_in, rx_end_in,
		rx_error_in, tx_ack_in, tx_error_in, tx_next_in} = '0;
	task automatic line(input logic [3:0] m);
		@(posedge mclk_in);
		{line_eop_in, line_reset_in, line_resume_in, line_activity_in} <= m;
		repeat (4) @(posedge mclk_in);
		{line_eop_in, line_reset_in, line_resume_in, line_activity_in} <= 4'h0;
	endtask
	task automatic tok(input logic d, input logic [6:0] a, input logic [3:0] e, output logic h);
		@(posedge mclk_in);
		{tok_in_dir_in, tok_addr_in, tok_ep_in, tok_valid_in} <= {d, a, e, 1'b1};
		@(posedge mclk_in);
		tok_valid_in <= 1'b0;
		h = 1'b0;
		repeat (2) begin
			@(posedge mclk_in);
			h = h | (ep_hit_out === 1'b1);
		end
	endtask
	task automatic rx(input int n, input logic e);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_in);
			{rx_valid_in, rx_data_in} <= {1'b1, 8'h30 + 8'(i)};
		end
		@(posedge mclk_in);
		{rx_valid_in, rx_end_in, rx_error_in, rx_data_in} <= {2'h1, e, ~rx_data_in};
		@(posedge mclk_in);
		{rx_end_in, rx_error_in} <= 2'h0;
	endtask
	task automatic hs(input logic e);
		repeat (2) begin
			@(posedge mclk_in);
			tx_next_in <= 1'b1;
			@(posedge mclk_in);
			tx_next_in <= 1'b0;
		end
		{tx_ack_in, tx_error_in} <= {!e, e};
		@(posedge mclk_in);
		{tx_ack_in, tx_error_in} <= 2'h0;
	endtask
endmodule // unsd_host_model

// file: verification/unsd_node_asserts.sv
`timescale 1ns/1ps
`include "unsd_map.vh"
module unsd_node_asserts (
	input logic mclk_in,
	input logic rst_in,
	input logic [2:0] avs_address_in,
	input logic avs_read_in,
	input logic avs_write_in,
	input logic [31:0] avs_writedata_in,
	input logic avs_waitrequest_out,
	input logic tok_valid_in,
	input logic drive_k_out,
	input logic low_power_out,
	input logic ep_hit_out
);
	// ----------
	// Checks
	// ----------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire st_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == `UNSD_A_NODE_STATE;
	wire [1:0] st_d = avs_writedata_in[1:0];
	bus_ans_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("No bus answer");
	ans_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("Answer too long");
	one_state_a: assert property (!(drive_k_out && low_power_out))
		else $error("Two states");
	wake_k_a: assert property (st_wr && st_d == `UNSD_ST_WAKE
		|-> ##[0:2] drive_k_out) else $error("No K");
	sleep_lp_a: assert property (st_wr && st_d == `UNSD_ST_SLEEP
		|-> ##[0:2] low_power_out) else $error("No low power");
	run_quiet_a: assert property (st_wr && st_d == `UNSD_ST_RUN
		|-> ##[0:2] !(drive_k_out || low_power_out)) else $error("Run not quiet");
	no_self_a: assert property (!avs_write_in [*3]
		|-> $stable({drive_k_out, low_power_out})) else $error("Self change");
	hit_tok_a: assert property (ep_hit_out |-> $past(tok_valid_in))
		else $error("Hit without token");
	hit_run_a: assert property (ep_hit_out |-> !drive_k_out && !low_power_out)
		else $error("Hit out of run");
endmodule // unsd_node_asserts
bind unsd_node unsd_node_asserts u_unsd_node_asserts (.*);
